// ==== adcc_defs.vh ====
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH
// register addresses
`define ADCC_ADDR_SCR 2'h0
`define ADCC_ADDR_DATA 2'h1
`define ADCC_ADDR_CLK 2'h2
`define ADCC_ADDR_PORT 2'h3
// status/control fields
`define ADCC_SCR_CONVERSION_COMPLETE_FLAG 7
`define ADCC_SCR_CONVERSION_INTERRUPT_ENABLE 6
`define ADCC_SCR_CONTINUOUS_CONVERSION_BIT 5
// clock register fields
`define ADCC_CLK_DIV_HI 7
`define ADCC_CLK_DIV_LO 5
`define ADCC_CLK_SRC 4
// reset values
`define ADCC_SCR_RESET 5'h1_F
`define ADCC_CLK_RESET 8'h00
// channel codes
`define ADCC_CH_HIGH_REFERENCE_INPUT 5'h1_D
`define ADCC_CH_LOW_REFERENCE_INPUT 5'h1_E
`define ADCC_CH_OFF 5'h1_F
`define ADCC_CH_PIN_MAX 5'h0_7
// conversion timing, in converter clock cycles
`define ADCC_CONV_CYCLES 5'h1_0
`endif

// ==== adcc_top.v ====
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "adcc_defs.vh"

module adcc_top (
  input wire REF_CLK_IN,
  input wire RST_IN,
  input wire [1:0] ADDR_IN,
  input wire [7:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output reg [7:0] RDATA_OUT,
  input wire ALT_CLK_IN,
  input wire COMP_HIGH_IN,
  output reg [7:0] SAR_TRIAL_OUT,
  output reg [2:0] ANALOG_SEL_OUT,
  output reg REF_HIGH_SEL_OUT,
  output reg REF_LOW_SEL_OUT,
  output reg POWER_DOWN_OUT,
  output reg SAMPLE_OUT,
  output reg CONV_IRQ_OUT,
  input wire [7:0] PORT_OUT_IN,
  input wire [7:0] PORT_DIR_IN,
  input wire [7:0] PIN_LEVEL_IN,
  output reg [7:0] PIN_DRIVE_OUT,
  output reg [7:0] PIN_OE_N_OUT,
  output reg [7:0] PORT_READ_OUT
);

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  reg [4:0] chan_q;
  reg cont_q;
  reg ien_q;
  reg conversion_complete_flag_q;
  reg [7:0] result_q;
  reg [2:0] div_q;
  reg src_q;
  reg [7:0] sar_q;
  reg [4:0] step_q;
  reg busy_q;
  reg start_q;
  reg [6:0] pre_q;
  reg tick_q;
  reg alt_q;
  reg alt_prev_q;

  wire scr_wr = WR_IN && (ADDR_IN == `ADCC_ADDR_SCR);
  wire data_rd = RD_IN && (ADDR_IN == `ADCC_ADDR_DATA);
  wire pin_sel = (chan_q <= `ADCC_CH_PIN_MAX);
  wire [7:0] sel_mask = pin_sel ? (8'h01 << chan_q[2:0]) : 8'h00;
  wire powered = (chan_q != `ADCC_CH_OFF);

  function [6:0] div_limit;
    input [2:0] d;
    begin
      case (d)
        3'h0: div_limit = 7'h00;
        3'h1: div_limit = 7'h01;
        3'h2: div_limit = 7'h03;
        3'h3: div_limit = 7'h07;
        default: div_limit = 7'h0F;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // converter clock: source select and prescaler, as a tick in this domain
  wire src_edge = src_q ? (alt_q && !alt_prev_q) : 1'b1;
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      alt_q <= 1'b0;
      alt_prev_q <= 1'b0;
      pre_q <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      alt_q <= ALT_CLK_IN;
      alt_prev_q <= alt_q;
      tick_q <= 1'b0;
      if (src_edge) begin
        if (pre_q >= div_limit(div_q)) begin
          pre_q <= 7'h00;
          tick_q <= 1'b1;
        end else begin
          pre_q <= pre_q + 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing strobes qualified by the converter tick, and the unqualified clock register write strobe clk_wr
  wire clk_wr = WR_IN && (ADDR_IN == `ADCC_ADDR_CLK);
  wire seq_tick = tick_q && powered && !scr_wr;
  wire seq_start = seq_tick && start_q;
  wire seq_step = seq_tick && !start_q && busy_q;
  wire last_step = (step_q == `ADCC_CONV_CYCLES - 5'h01);
  wire seq_done = seq_step && last_step;
  // two converter cycles per bit: settle on even steps, decide on odd ones
  wire decide = seq_step && step_q[0] && !step_q[4];
  wire [7:0] dec_mask = 8'h80 >> step_q[3:1];
  wire [7:0] try_mask = 8'h40 >> step_q[3:1];
  wire [7:0] sar_next;

  ////////////////////////////////////////////////////////////////////////////////
  // next trial word: the decided bit takes the comparator, the next bit is tried
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb = gb + 1) begin : g_sar_bit
      assign sar_next[gb] = dec_mask[gb] ? COMP_HIGH_IN : (try_mask[gb] | sar_q[gb]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // status and control register fields
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      chan_q <= `ADCC_SCR_RESET;
      cont_q <= 1'b0;
      ien_q <= 1'b0;
    end else if (scr_wr) begin
      chan_q <= WDATA_IN[4:0];
      cont_q <= WDATA_IN[`ADCC_SCR_CONTINUOUS_CONVERSION_BIT];
      ien_q <= WDATA_IN[`ADCC_SCR_CONVERSION_INTERRUPT_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // converter clock register
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      div_q <= 3'h0;
      src_q <= 1'b0;
    end else if (clk_wr) begin
      div_q <= WDATA_IN[`ADCC_CLK_DIV_HI:`ADCC_CLK_DIV_LO];
      src_q <= WDATA_IN[`ADCC_CLK_SRC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion state: pending start, busy and step count
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      step_q <= 5'h00;
      busy_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      if (scr_wr) begin
        // a control write abandons whatever is running
        busy_q <= 1'b0;
        start_q <= (WDATA_IN[4:0] != `ADCC_CH_OFF);
      end else if (!powered) begin
        busy_q <= 1'b0;
        start_q <= 1'b0;
      end else if (seq_start) begin
        start_q <= 1'b0;
        busy_q <= 1'b1;
        step_q <= 5'h00;
      end else if (seq_step) begin
        step_q <= step_q + 5'h01;
        if (last_step) begin
          busy_q <= 1'b0;
          start_q <= cont_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // successive approximation register
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sar_q <= 8'h00;
    end else begin
      if (seq_start) begin
        sar_q <= 8'h80;
      end else if (decide) begin
        sar_q <= sar_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // result register, loaded with the last decided bit included
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      result_q <= 8'h00;
    end else begin
      if (seq_done) begin
        result_q <= sar_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // completion flag: end of conversion wins over a result read
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      conversion_complete_flag_q <= 1'b0;
    end else begin
      if (seq_done && !ien_q) begin
        conversion_complete_flag_q <= 1'b1;
      end else if (data_rd) begin
        conversion_complete_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion interrupt level
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CONV_IRQ_OUT <= 1'b0;
    end else begin
      if (scr_wr) begin
        CONV_IRQ_OUT <= 1'b0;
      end else if (seq_done && ien_q) begin
        CONV_IRQ_OUT <= 1'b1;
      end else if (data_rd) begin
        CONV_IRQ_OUT <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // analog side: trial word, sampling and input selection
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      SAR_TRIAL_OUT <= 8'h00;
      SAMPLE_OUT <= 1'b0;
    end else begin
      SAR_TRIAL_OUT <= sar_q;
      SAMPLE_OUT <= busy_q;
    end
  end

  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ANALOG_SEL_OUT <= 3'h0;
      REF_HIGH_SEL_OUT <= 1'b0;
      REF_LOW_SEL_OUT <= 1'b0;
      POWER_DOWN_OUT <= 1'b1;
    end else begin
      ANALOG_SEL_OUT <= chan_q[2:0];
      REF_HIGH_SEL_OUT <= (chan_q == `ADCC_CH_HIGH_REFERENCE_INPUT);
      REF_LOW_SEL_OUT <= (chan_q == `ADCC_CH_LOW_REFERENCE_INPUT);
      POWER_DOWN_OUT <= !powered;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared pins: the selected one is taken from the port logic
  genvar gp;
  generate
    for (gp = 0; gp < 8; gp = gp + 1) begin : g_pin
      wire taken = sel_mask[gp];
      always @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          PIN_DRIVE_OUT[gp] <= 1'b0;
          PIN_OE_N_OUT[gp] <= 1'b1;
          PORT_READ_OUT[gp] <= 1'b0;
        end else if (taken) begin
          PIN_DRIVE_OUT[gp] <= 1'b0;
          PIN_OE_N_OUT[gp] <= 1'b1;
          PORT_READ_OUT[gp] <= 1'b0;
        end else begin
          PIN_DRIVE_OUT[gp] <= PORT_OUT_IN[gp];
          PIN_OE_N_OUT[gp] <= !PORT_DIR_IN[gp];
          PORT_READ_OUT[gp] <= PIN_LEVEL_IN[gp];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // register read data, standing for one cycle after the read strobe
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 8'h00;
    end else begin
      RDATA_OUT <= 8'h00;
      if (RD_IN) begin
        if (ADDR_IN == `ADCC_ADDR_SCR) begin
          RDATA_OUT <= {conversion_complete_flag_q && !ien_q, ien_q, cont_q, chan_q};
        end else if (ADDR_IN == `ADCC_ADDR_DATA) begin
          RDATA_OUT <= result_q;
        end else if (ADDR_IN == `ADCC_ADDR_CLK) begin
          RDATA_OUT <= {div_q, src_q, 4'h0};
        end else begin
          RDATA_OUT <= PIN_LEVEL_IN & ~sel_mask;
        end
      end
    end
  end

endmodule // adcc_top
`default_nettype wire

// ==== adcc_top_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcc_chk (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic [1:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic [2:0] ANALOG_SEL_OUT,
  input wire logic REF_HIGH_SEL_OUT,
  input wire logic REF_LOW_SEL_OUT,
  input wire logic POWER_DOWN_OUT,
  input wire logic SAMPLE_OUT,
  input wire logic CONV_IRQ_OUT,
  input wire logic [7:0] PORT_DIR_IN,
  input wire logic [7:0] PIN_OE_N_OUT,
  input wire logic [7:0] PORT_READ_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  wire pin_sel = !POWER_DOWN_OUT && !REF_HIGH_SEL_OUT && !REF_LOW_SEL_OUT;
  sequence s_start; $rose(SAMPLE_OUT); endsequence
  sequence s_res_rd; RD_IN && ADDR_IN == 2'h1 && !SAMPLE_OUT; endsequence
  a_sel_input: assert property (pin_sel && $stable(ANALOG_SEL_OUT) |-> PIN_OE_N_OUT[ANALOG_SEL_OUT])
    else $error("selected pin driven");
  a_sel_reads_zero: assert property (pin_sel |-> !PORT_READ_OUT[ANALOG_SEL_OUT])
    else $error("selected pin reads one");
  a_idle_port_dir: assert property (POWER_DOWN_OUT && $past(POWER_DOWN_OUT) |-> PIN_OE_N_OUT == ~$past(PORT_DIR_IN))
    else $error("port direction ignored");
  a_irq_wr_clear: assert property (WR_IN && ADDR_IN == 2'h0 |=> !CONV_IRQ_OUT)
    else $error("irq after control write");
  a_irq_rd_clear: assert property (s_res_rd |=> !CONV_IRQ_OUT)
    else $error("irq after result read");
  a_flag_zero_ien: assert property ($past(RD_IN) && $past(ADDR_IN) == 2'h0 && RDATA_OUT[6] |-> !RDATA_OUT[7])
    else $error("flag set with irq enabled");
  a_conv_min_len: assert property (s_start ##1 (!WR_IN) [*7] |-> SAMPLE_OUT)
    else $error("conversion too short");
  a_pd_no_conv: assert property (POWER_DOWN_OUT && $past(POWER_DOWN_OUT) |-> !SAMPLE_OUT)
    else $error("converting while off");
endmodule // adcc_chk
bind adcc_top adcc_chk i_chk (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .ANALOG_SEL_OUT(ANALOG_SEL_OUT),
  .REF_HIGH_SEL_OUT(REF_HIGH_SEL_OUT), .REF_LOW_SEL_OUT(REF_LOW_SEL_OUT),
  .POWER_DOWN_OUT(POWER_DOWN_OUT), .SAMPLE_OUT(SAMPLE_OUT), .CONV_IRQ_OUT(CONV_IRQ_OUT),
  .PORT_DIR_IN(PORT_DIR_IN), .PIN_OE_N_OUT(PIN_OE_N_OUT), .PORT_READ_OUT(PORT_READ_OUT));
`default_nettype wire

// ==== adcc_analog_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcc_analog_model (
  input wire logic [63:0] pin_volts_in,
  input wire logic [2:0] sel_in,
  input wire logic ref_high_in,
  input wire logic ref_low_in,
  input wire logic [7:0] trial_in,
  output logic comp_high_out
);
  logic [7:0] vin;
  always_comb begin
    vin = ref_high_in ? 8'hFF : ref_low_in ? 8'h00 : pin_volts_in[sel_in*8 +: 8];
    comp_high_out = vin >= trial_in;
  end
endmodule // adcc_analog_model
`default_nettype wire

// ==== test_adcc_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module test_adcc_top;
  logic REF_CLK_IN, RST_IN = 1, WR_IN = 0, RD_IN = 0, ALT_CLK_IN = 0, COMP_HIGH_IN;
  logic [1:0] ADDR_IN = 0;
  logic [7:0] WDATA_IN = 0, PORT_OUT_IN = 0, PORT_DIR_IN = 0, PIN_LEVEL_IN = 0, rv;
  logic [7:0] RDATA_OUT, SAR_TRIAL_OUT, PIN_DRIVE_OUT, PIN_OE_N_OUT, PORT_READ_OUT;
  logic [2:0] ANALOG_SEL_OUT;
  logic REF_HIGH_SEL_OUT, REF_LOW_SEL_OUT, POWER_DOWN_OUT, SAMPLE_OUT, CONV_IRQ_OUT;
  logic [63:0] ain = 0;
  int errors = 0, n_checks = 0, cyc = 0;
  adcc_top i_dut (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .ALT_CLK_IN(ALT_CLK_IN), .COMP_HIGH_IN(COMP_HIGH_IN), .SAR_TRIAL_OUT(SAR_TRIAL_OUT),
    .ANALOG_SEL_OUT(ANALOG_SEL_OUT), .REF_HIGH_SEL_OUT(REF_HIGH_SEL_OUT),
    .REF_LOW_SEL_OUT(REF_LOW_SEL_OUT), .POWER_DOWN_OUT(POWER_DOWN_OUT),
    .SAMPLE_OUT(SAMPLE_OUT), .CONV_IRQ_OUT(CONV_IRQ_OUT), .PORT_OUT_IN(PORT_OUT_IN),
    .PORT_DIR_IN(PORT_DIR_IN), .PIN_LEVEL_IN(PIN_LEVEL_IN), .PIN_DRIVE_OUT(PIN_DRIVE_OUT),
    .PIN_OE_N_OUT(PIN_OE_N_OUT), .PORT_READ_OUT(PORT_READ_OUT));
  adcc_analog_model i_ana (.pin_volts_in(ain), .sel_in(ANALOG_SEL_OUT),
    .ref_high_in(REF_HIGH_SEL_OUT), .ref_low_in(REF_LOW_SEL_OUT), .trial_in(SAR_TRIAL_OUT),
    .comp_high_out(COMP_HIGH_IN));
  initial begin
    REF_CLK_IN = 0;
    forever #25 REF_CLK_IN = ~REF_CLK_IN;
  end
  always @(posedge REF_CLK_IN) begin
    ALT_CLK_IN <= ~ALT_CLK_IN;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge REF_CLK_IN);
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= 1;
    @(posedge REF_CLK_IN);
    WR_IN <= 0;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge REF_CLK_IN);
    ADDR_IN <= a;
    RD_IN <= 1;
    @(posedge REF_CLK_IN);
    RD_IN <= 0;
    @(negedge REF_CLK_IN);
    rv = RDATA_OUT;
  endtask
  task automatic wait_conv;
    int n;
    n = 0;
    repeat (6) @(posedge REF_CLK_IN);
    while (SAMPLE_OUT !== 1'b0 && n < 500) begin
      @(negedge REF_CLK_IN);
      n++;
    end
  endtask
  task automatic conv(input logic [4:0] ch, input logic [7:0] exp);
    wr_reg(0, {3'b000, ch});
    wait_conv();
    rd_reg(0);
    `CHK(rv, {3'b100, ch})
    rd_reg(3);
    if (ch < 8) `CHK(rv, ~(8'h01 << ch[2:0]))
    if (ch < 8) `CHK(PIN_DRIVE_OUT, PORT_OUT_IN & ~(8'h01 << ch[2:0]))
    if (ch < 8) `CHK(PIN_OE_N_OUT, ~(PORT_DIR_IN & ~(8'h01 << ch[2:0])))
    rd_reg(1);
    `CHK(rv, exp)
    rd_reg(0);
    `CHK(rv[7], 1'b0)
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h1917));
    repeat (12) @(posedge REF_CLK_IN);
    RST_IN <= 0;
    rd_reg(0);
    `CHK(rv, 8'h1F)
    `CHK(POWER_DOWN_OUT, 1'b1)
    @(posedge REF_CLK_IN);
    PIN_LEVEL_IN <= 8'hFF;
    wr_reg(2, 8'h00);
    for (int i = 0; i < 10; i++) begin
      @(posedge REF_CLK_IN);
      ain <= {$urandom, $urandom};
      PORT_DIR_IN <= 8'($urandom);
      PORT_OUT_IN <= 8'($urandom);
      @(posedge REF_CLK_IN);
      conv(i < 8 ? i[4:0] : 5'h1D + i[4:0] - 5'h08, i < 8 ? ain[i*8 +: 8] : {8{i == 8}});
    end
    $display("test channels done");
    wr_reg(0, 8'h02);
    repeat (4) @(posedge REF_CLK_IN);
    conv(5'h05, ain[47:40]);
    wr_reg(2, 8'h30);
    conv(5'h03, ain[31:24]);
    wr_reg(2, 8'h00);
    $display("test restart and clock done");
    wr_reg(0, 8'h42);
    wait_conv();
    `CHK(CONV_IRQ_OUT, 1'b1)
    rd_reg(0);
    `CHK(rv, 8'h42)
    rd_reg(1);
    `CHK(CONV_IRQ_OUT, 1'b0)
    $display("test irq done");
    wr_reg(0, 8'h21);
    repeat (30) @(posedge REF_CLK_IN);
    ain[15:8] <= ~ain[15:8];
    repeat (40) @(posedge REF_CLK_IN);
    rd_reg(1);
    `CHK(rv, ain[15:8])
    wr_reg(0, 8'h01);
    wait_conv();
    repeat (40) @(posedge REF_CLK_IN);
    `CHK(SAMPLE_OUT, 1'b0)
    $display("test continuous done");
    stop_test();
  end
endmodule // test_adcc_top
`default_nettype wire
